// ==== activity_power_manager_bench.sv ====
// Purpose: self-checking bench of the activity power manager
// Assumes: shortened idle and wake counts
// Notes:   the host model wires the valid flag back in the tie tests
`timescale 1ns/10ps
`default_nettype none
module activity_power_manager_bench;
  import apm_pkg::*;
  localparam int IDLE = 200;
  localparam int WAKE = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        force_off_n, auto_mode_select_n, req_off_n, req_auto_n, vneg;
  logic [1:0]  tie, tx_in, rx_in, lvl, tx_out, tx_out_oe, rx_out;
  logic        pump_enable, valid_level, pump_ready, irq;
  int          n_errors = 0;
  int          checks = 0;
  apm_top #(.IDLE_CYCLES(APM_IDLE_W'(IDLE)),
    .AUTO_MODE_SELECT_N_CYCLES(APM_WAKE_W'(WAKE))) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .force_off_n(force_off_n), .auto_mode_select_n(auto_mode_select_n),
    .tx_in(tx_in), .rx_in(rx_in), .rx_level_ok(lvl), .vneg_below_4v(vneg),
    .tx_out(tx_out), .tx_out_oe(tx_out_oe), .rx_out(rx_out),
    .pump_enable(pump_enable), .valid_level(valid_level),
    .pump_ready(pump_ready), .irq(irq));
  apm_host_model u_host (.tie(tie), .req_off_n(req_off_n),
    .req_auto_n(req_auto_n), .valid_level(valid_level),
    .force_off_n(force_off_n), .auto_mode_select_n(auto_mode_select_n));
  // clock
  always #2 pclk = ~pclk;
  // verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string n, input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) begin
      n_errors++;
      $display("MISMATCH pready expected 1 seen 0");
      print_verdict();
    end
  endtask
  // wait for pump_enable (s=0) or all driver enables (s=1)
  task automatic wait_sig(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge pclk);
      if ((s ? &tx_out_oe : pump_enable) === v) break;
    end
    if (i >= lim) begin
      n_errors++;
      $display("MISMATCH wait %0d expected %b seen timeout", s, v);
      print_verdict();
    end
  endtask
  // main sequence
  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    req_off_n = 1;
    req_auto_n = 0;
    tie = '0;
    tx_in = '0;
    rx_in = 2'h3;
    lvl = 2'h3;
    vneg = 1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wait_sig(0, 1'b1, 20);
    chk("oe early", 32'(tx_out_oe), 32'h0);
    wait_sig(1, 1'b1, WAKE + 10);
    tx_in <= 2'h2;
    repeat (6) @(posedge pclk);
    chk("tx_out", 32'(tx_out), 32'h2);
    chk("ready", 32'(pump_ready), 32'h1);
    chk("valid", 32'(valid_level), 32'h1);
    apb(1'b1, APM_OFS_CTRL, 32'h1);
    apb(1'b0, APM_OFS_IDLE_CNT, '0);
    chk("idle restart", 32'(rd < 32'h4), 32'h1);
    apb(1'b0, APM_OFS_IRQ_MASK, '0);
    chk("mask reset", rd, 32'(APM_IRQ_MASK_RST));
    apb(1'b1, APM_OFS_IRQ_MASK, 32'h1);
    apb(1'b0, 12'h020, '0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped rd", rd, 32'h0);
    apb(1'b0, APM_OFS_IRQ_STAT, '0);
    chk("events", rd, 32'h0000_000e);
    $display("test wake and registers done");
    wait_sig(0, 1'b0, IDLE + WAKE + 50);
    repeat (3) @(posedge pclk);
    chk("sleep oe", 32'(tx_out_oe), 32'h0);
    chk("sleep ready", 32'(pump_ready), 32'h0);
    chk("irq raised", 32'(irq), 32'h1);
    apb(1'b1, APM_OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b0, APM_OFS_IRQ_STAT, '0);
    chk("sleep event", rd & 32'h1, 32'h1);
    apb(1'b1, APM_OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'(irq), 32'h0);
    rx_in <= 2'h1;
    wait_sig(0, 1'b1, 10);
    wait_sig(1, 1'b1, WAKE + 10);
    $display("test idle and wake done");
    req_auto_n <= 1'b1;
    req_off_n <= 1'b0;
    repeat (2) @(posedge pclk);
    rx_in <= 2'h2;
    repeat (6) @(posedge pclk);
    chk("off pump", 32'(pump_enable), 32'h0);
    chk("off oe", 32'(tx_out_oe), 32'h0);
    chk("off rx", 32'(rx_out), 32'h2);
    req_off_n <= 1'b1;
    wait_sig(1, 1'b1, WAKE + 20);
    repeat (IDLE + WAKE + 50) @(posedge pclk);
    chk("forced on", 32'(tx_out_oe), 32'h3);
    apb(1'b0, APM_OFS_STATUS, '0);
    chk("status", rd, 32'h0000_007f);
    apb(1'b0, APM_OFS_IDLE_CNT, '0);
    chk("idle forced", rd, 32'h0);
    vneg <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("ready low", 32'(pump_ready), 32'h0);
    vneg <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("ready high", 32'(pump_ready), 32'h1);
    $display("test forced modes done");
    lvl <= 2'h0;
    tie <= 2'h1;
    repeat (6) @(posedge pclk);
    chk("valid low", 32'(valid_level), 32'h0);
    wait_sig(0, 1'b0, IDLE + WAKE + 50);
    lvl <= 2'h1;
    wait_sig(1, 1'b1, WAKE + 20);
    tie <= 2'h2;
    lvl <= 2'h0;
    repeat (8) @(posedge pclk);
    chk("tie off", 32'(pump_enable), 32'h0);
    lvl <= 2'h2;
    wait_sig(1, 1'b1, WAKE + 20);
    $display("test flag wiring done");
    print_verdict();
  end
  // overall limit on the run
  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    $display("MISMATCH run expected end seen timeout");
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== apm_host_model.sv ====
// Purpose: host wiring of the power control pins
// Assumes: tie 0 direct, 1 flag to select, 2 flag to both pins
// Notes:   purely combinational board wiring
`timescale 1ns/10ps
`default_nettype none
module apm_host_model (
  // host requests
  input  wire logic [1:0] tie,
  input  wire logic       req_off_n,
  input  wire logic       req_auto_n,
  // flag from the device
  input  wire logic       valid_level,
  // control pins
  output var  logic       force_off_n,
  output var  logic       auto_mode_select_n
);
  // route the flag back where the board ties it
  always_comb begin
    auto_mode_select_n = (tie != 2'h0) ? valid_level : req_auto_n;
    force_off_n = (tie == 2'h2) ? valid_level : req_off_n;
  end
endmodule
`default_nettype wire

// ==== apm_pkg.sv ====
// Purpose: constants and register map of the activity power manager
// Assumes: pclk at 250 MHz, APB register access with 32-bit data
// Notes:   long cycle counts are also top-level parameters
`default_nettype none
package apm_pkg;

  // clock and timing
  localparam longint unsigned APM_CLK_HZ      = 250_000_000;
  localparam longint unsigned APM_IDLE_S      = 30;
  localparam longint unsigned APM_AUTO_MODE_SELECT_N_US   = 100;
  localparam longint unsigned APM_IDLE_CYC_L  = APM_IDLE_S * APM_CLK_HZ;
  localparam longint unsigned APM_AUTO_MODE_SELECT_N_CYC_L =
    (APM_AUTO_MODE_SELECT_N_US * APM_CLK_HZ) / 64'd1_000_000;
  localparam int              APM_IDLE_W      = 36;
  localparam int              APM_WAKE_W      = 20;
  localparam logic [APM_IDLE_W-1:0] APM_IDLE_CYCLES =
    APM_IDLE_CYC_L[APM_IDLE_W-1:0];
  localparam logic [APM_WAKE_W-1:0] APM_AUTO_MODE_SELECT_N_CYCLES =
    APM_AUTO_MODE_SELECT_N_CYC_L[APM_WAKE_W-1:0];

  // register byte offsets
  localparam logic [11:0] APM_OFS_CTRL     = 12'h000;
  localparam logic [11:0] APM_OFS_STATUS   = 12'h004;
  localparam logic [11:0] APM_OFS_IRQ_STAT = 12'h008;
  localparam logic [11:0] APM_OFS_IRQ_MASK = 12'h00c;
  localparam logic [11:0] APM_OFS_IDLE_CNT = 12'h010;

  // control fields
  localparam int APM_CTRL_SW_ACT = 0;

  // status fields
  localparam int APM_ST_STATE_LO = 0;
  localparam int APM_ST_PUMP_EN  = 2;
  localparam int APM_ST_DRV_EN   = 3;
  localparam int APM_ST_VALID    = 4;
  localparam int APM_ST_READY    = 5;
  localparam int APM_ST_FORCE_ON = 6;
  localparam int APM_ST_FORCE_OFF = 7;

  // interrupt event bits
  localparam int APM_IRQ_W       = 4;
  localparam int APM_EV_SLEEP    = 0;
  localparam int APM_EV_AUTO_MODE_SELECT_N   = 1;
  localparam int APM_EV_VALID    = 2;
  localparam int APM_EV_READY    = 3;

  // reset values
  localparam logic [APM_IRQ_W-1:0] APM_IRQ_MASK_RST = 4'h0;

  // power states, gray along sleep -> waking -> active
  typedef enum logic [1:0] {
    APM_SLEEP  = 2'b00,
    APM_WAKING = 2'b01,
    APM_ACTIVE = 2'b11,
    APM_OFF    = 2'b10
  } apm_state_t;

endpackage
`default_nettype wire

// ==== apm_properties.sv ====
// Purpose: port checks of the activity power manager
// Assumes: control pins stay steady while an idle sleep is timed
// Notes:   counts follow the top-level parameters
`timescale 1ns/10ps
`default_nettype none
module apm_properties #(
  parameter int IDLE_CYCLES   = 200,
  parameter int AUTO_MODE_SELECT_N_CYCLES = 20
) (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // watched inputs
  input wire logic       force_off_n,
  input wire logic       auto_mode_select_n,
  input wire logic [1:0] tx_in,
  input wire logic [1:0] rx_in,
  input wire logic [1:0] rx_level_ok,
  input wire logic       vneg_below_4v,
  // watched outputs
  input wire logic [1:0] tx_out_oe,
  input wire logic [1:0] rx_out,
  input wire logic       pump_enable,
  input wire logic       valid_level,
  input wire logic       pump_ready
);
  localparam int WAKE_LO  = AUTO_MODE_SELECT_N_CYCLES - 3;
  localparam int SLEEP_HI = IDLE_CYCLES + AUTO_MODE_SELECT_N_CYCLES + 10;
  logic [3:0]  pins_q;
  logic [15:0] quiet;
  logic [15:0] forced;
  logic        auto_on;
  logic        edge_seen;
  // pin edges and automatic mode as the host sees them
  assign auto_on   = force_off_n && !auto_mode_select_n;
  assign edge_seen = {tx_in, rx_in} != pins_q;
  // quiet cycles in automatic mode, cycles in forced-on mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= '0;
      quiet  <= '0;
      forced <= '0;
    end else begin
      pins_q <= {tx_in, rx_in};
      quiet  <= (edge_seen || !auto_on) ? '0 : quiet + 16'(quiet != '1);
      forced <= !(force_off_n && auto_mode_select_n) ? '0 :
                forced + 16'(forced != '1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_force_off: assert property (!force_off_n [*5] |-> !pump_enable
    && tx_out_oe == '0 && !pump_ready) else $error("forced off not down");
  a_valid_low: assert property ((rx_level_ok == '0) [*5] |-> !valid_level)
    else $error("valid flag high without level");
  a_valid_high: assert property ((rx_level_ok != '0) [*5] |-> valid_level)
    else $error("valid flag low with level");
  a_ready_gate: assert property (pump_ready |-> $past(pump_enable))
    else $error("ready without pump");
  a_ready_rise: assert property ((vneg_below_4v && pump_enable) [*5]
    |-> pump_ready) else $error("ready missing");
  a_rx_follow: assert property ($stable(rx_in) [*5] |-> rx_out == rx_in)
    else $error("receiver output stale");
  a_forced_on: assert property (forced > 16'(AUTO_MODE_SELECT_N_CYCLES + 8)
    |-> tx_out_oe == '1 && pump_enable) else $error("forced on not up");
  a_idle_sleep: assert property (quiet > 16'(SLEEP_HI)
    |-> !pump_enable && tx_out_oe == '0) else $error("idle sleep missing");
  a_sleep_early: assert property ($fell(pump_enable) && force_off_n
    && $past(force_off_n, 4) |-> quiet >= 16'(IDLE_CYCLES - 1))
    else $error("sleep too early");
  a_wake_edge: assert property (edge_seen && auto_on && $past(auto_on, 4)
    |-> ##[1:6] pump_enable) else $error("edge did not wake");
  a_wake_delay: assert property ($rose(pump_enable) |-> ##WAKE_LO
    tx_out_oe == '0 ##[1:8] tx_out_oe == '1) else $error("wake delay off");
  c_sleep: cover property ($fell(pump_enable) && force_off_n);
  c_wake: cover property ($rose(tx_out_oe[0]));
  c_off: cover property (!force_off_n [*5]);
endmodule
bind apm_top apm_properties #(.IDLE_CYCLES(IDLE_CYCLES),
  .AUTO_MODE_SELECT_N_CYCLES(AUTO_MODE_SELECT_N_CYCLES)) u_props (.pclk(pclk), .presetn(presetn),
  .force_off_n(force_off_n), .auto_mode_select_n(auto_mode_select_n),
  .tx_in(tx_in), .rx_in(rx_in), .rx_level_ok(rx_level_ok),
  .vneg_below_4v(vneg_below_4v), .tx_out_oe(tx_out_oe), .rx_out(rx_out),
  .pump_enable(pump_enable), .valid_level(valid_level),
  .pump_ready(pump_ready));
`default_nettype wire

// ==== apm_top.sv ====
// Purpose: transition-driven power manager for a serial line transceiver
// Assumes: pump rail and line level comparators arrive as digital inputs
// Notes:   receiver data keeps flowing in every power state
//
// The register offsets and register access over APB were chosen for this implementation.
`default_nettype none
`timescale 1ns/10ps

module apm_top
  import apm_pkg::*;
#(
  parameter int                    N_DRV       = 2,
  parameter int                    N_RCV       = 2,
  parameter logic [APM_IDLE_W-1:0] IDLE_CYCLES = APM_IDLE_CYCLES,
  parameter logic [APM_WAKE_W-1:0] AUTO_MODE_SELECT_N_CYCLES = APM_AUTO_MODE_SELECT_N_CYCLES
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  // power control pins
  input  wire logic             force_off_n,
  input  wire logic             auto_mode_select_n,
  // monitored driver and receiver inputs
  input  wire logic [N_DRV-1:0] tx_in,
  input  wire logic [N_RCV-1:0] rx_in,
  // analog comparator results
  input  wire logic [N_RCV-1:0] rx_level_ok,
  input  wire logic             vneg_below_4v,
  // line side outputs
  output var  logic [N_DRV-1:0] tx_out,
  output var  logic [N_DRV-1:0] tx_out_oe,
  output var  logic [N_RCV-1:0] rx_out,
  // power outputs and flags
  output var  logic             pump_enable,
  output var  logic             valid_level,
  output var  logic             pump_ready,
  output var  logic             irq
);

  typedef struct packed {
    logic                  fo_s1;
    logic                  fo_s2;
    logic                  am_s1;
    logic                  am_s2;
    logic [N_DRV-1:0]      tx_s1;
    logic [N_DRV-1:0]      tx_s2;
    logic [N_DRV-1:0]      tx_s3;
    logic [N_RCV-1:0]      rx_s1;
    logic [N_RCV-1:0]      rx_s2;
    logic [N_RCV-1:0]      rx_s3;
    logic [N_RCV-1:0]      lv_s1;
    logic [N_RCV-1:0]      lv_s2;
    logic                  vn_s1;
    logic                  vn_s2;
    logic [1:0]            prime;
    apm_state_t            state;
    logic [APM_IDLE_W-1:0] idle_cnt;
    logic [APM_WAKE_W-1:0] wake_cnt;
    logic                  sw_act;
    logic [APM_IRQ_W-1:0]  irq_stat;
    logic [APM_IRQ_W-1:0]  irq_mask;
    logic [N_DRV-1:0]      tx_out;
    logic [N_DRV-1:0]      tx_out_oe;
    logic [N_RCV-1:0]      rx_out;
    logic                  pump_enable;
    logic                  valid_level;
    logic                  pump_ready;
    logic                  irq;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } apm_regs_t;

  apm_regs_t r;
  apm_regs_t next_r;

  // true when the address names a mapped register
  function automatic logic apm_mapped(input logic [11:0] a);
    if (a == APM_OFS_CTRL) begin
      return 1'b1;
    end else if (a == APM_OFS_STATUS) begin
      return 1'b1;
    end else if (a == APM_OFS_IRQ_STAT) begin
      return 1'b1;
    end else if (a == APM_OFS_IRQ_MASK) begin
      return 1'b1;
    end else if (a == APM_OFS_IDLE_CNT) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic                 forced_off;
    logic                 forced_on;
    logic                 activity;
    logic                 apb_done;
    logic                 apb_req;
    logic                 pumps_on;
    logic [APM_IRQ_W-1:0] ev;
    logic [31:0]          rd;
    forced_off = 1'b0;
    forced_on  = 1'b0;
    activity   = 1'b0;
    apb_done   = 1'b0;
    apb_req    = 1'b0;
    pumps_on   = 1'b0;
    ev         = '0;
    rd         = 32'h0000_0000;
    next_r     = r;

    // two-flop synchronisers for every pin
    next_r.fo_s1 = force_off_n;
    next_r.fo_s2 = r.fo_s1;
    next_r.am_s1 = auto_mode_select_n;
    next_r.am_s2 = r.am_s1;
    next_r.tx_s1 = tx_in;
    next_r.tx_s2 = r.tx_s1;
    next_r.tx_s3 = r.tx_s2;
    next_r.rx_s1 = rx_in;
    next_r.rx_s2 = r.rx_s1;
    next_r.rx_s3 = r.rx_s2;
    next_r.lv_s1 = rx_level_ok;
    next_r.lv_s2 = r.lv_s1;
    next_r.vn_s1 = vneg_below_4v;
    next_r.vn_s2 = r.vn_s1;

    // edge detectors stay blind until the synchroniser chain has filled,
    // so the reset value of the chain never reads as a pin edge
    if (r.prime != 2'h3) begin
      next_r.prime = r.prime + 2'h1;
    end

    // control decode from the pins
    forced_off = !r.fo_s2;
    forced_on  = r.am_s2 && r.fo_s2;
    // pin edges or a software activity write; the valid flag takes no part here
    activity = ((r.prime == 2'h3)
                && ((|(r.tx_s2 ^ r.tx_s3)) || (|(r.rx_s2 ^ r.rx_s3))))
               || r.sw_act;

    // apb handshake: one wait state, then pready
    apb_req  = psel && penable && !r.pready;
    apb_done = psel && penable && r.pready;
    next_r.pready  = apb_req;
    next_r.pslverr = apb_req && !apm_mapped(paddr);
    next_r.sw_act  = 1'b0;

    // power state machine
    next_r.wake_cnt = '0;
    case (r.state)
      APM_OFF: begin
        if (!forced_off) begin
          next_r.state = APM_WAKING;
        end
      end
      APM_SLEEP: begin
        if (forced_off) begin
          next_r.state = APM_OFF;
        end else if (forced_on || activity) begin
          next_r.state = APM_WAKING;
        end
      end
      APM_WAKING: begin
        if (forced_off) begin
          next_r.state = APM_OFF;
        end else if (r.wake_cnt >= AUTO_MODE_SELECT_N_CYCLES - 1'b1) begin
          next_r.state = APM_ACTIVE;
        end else begin
          next_r.wake_cnt = r.wake_cnt + 1'b1;
        end
      end
      APM_ACTIVE: begin
        if (forced_off) begin
          next_r.state = APM_OFF;
        end else if (!forced_on && !activity
                     && r.idle_cnt >= IDLE_CYCLES - 1'b1) begin
          next_r.state = APM_SLEEP;
        end
      end
      default: begin
        next_r.state = APM_OFF;
      end
    endcase

    // idle timer runs only while powered in automatic mode
    if (forced_on || forced_off || activity
        || r.state == APM_SLEEP || r.state == APM_OFF) begin
      next_r.idle_cnt = '0;
    end else if (r.idle_cnt < IDLE_CYCLES) begin
      next_r.idle_cnt = r.idle_cnt + 1'b1;
    end

    // output stage
    pumps_on = (next_r.state == APM_WAKING)
               || (next_r.state == APM_ACTIVE);
    next_r.pump_enable = pumps_on;
    next_r.tx_out_oe   = {N_DRV{next_r.state == APM_ACTIVE}};
    next_r.tx_out      = r.tx_s2;
    next_r.rx_out      = r.rx_s2;
    next_r.valid_level = |r.lv_s2;
    next_r.pump_ready  = r.vn_s2 && r.pump_enable;

    // interrupt events
    ev[APM_EV_SLEEP]  = (r.state != APM_SLEEP)
                        && (next_r.state == APM_SLEEP);
    ev[APM_EV_AUTO_MODE_SELECT_N] = (r.state != APM_ACTIVE)
                        && (next_r.state == APM_ACTIVE);
    ev[APM_EV_VALID]  = next_r.valid_level != r.valid_level;
    ev[APM_EV_READY]  = next_r.pump_ready && !r.pump_ready;

    // read data mux
    if (paddr == APM_OFS_CTRL) begin
      rd = 32'h0000_0000;
    end else if (paddr == APM_OFS_STATUS) begin
      rd[APM_ST_STATE_LO +: 2]  = r.state;
      rd[APM_ST_PUMP_EN]        = r.pump_enable;
      rd[APM_ST_DRV_EN]         = |r.tx_out_oe;
      rd[APM_ST_VALID]          = r.valid_level;
      rd[APM_ST_READY]          = r.pump_ready;
      rd[APM_ST_FORCE_ON]       = forced_on;
      rd[APM_ST_FORCE_OFF]      = forced_off;
    end else if (paddr == APM_OFS_IRQ_STAT) begin
      rd[APM_IRQ_W-1:0] = r.irq_stat;
    end else if (paddr == APM_OFS_IRQ_MASK) begin
      rd[APM_IRQ_W-1:0] = r.irq_mask;
    end else if (paddr == APM_OFS_IDLE_CNT) begin
      rd = r.idle_cnt[31:0];
    end else begin
      rd = 32'h0000_0000;
    end
    if (apb_req) begin
      next_r.prdata = pwrite ? 32'h0000_0000 : rd;
    end

    // register writes at the completing edge
    if (apb_done && pwrite) begin
      if (paddr == APM_OFS_CTRL) begin
        next_r.sw_act = pwdata[APM_CTRL_SW_ACT];
      end else if (paddr == APM_OFS_IRQ_MASK) begin
        next_r.irq_mask = pwdata[APM_IRQ_W-1:0];
      end
    end

    // sticky status: a read clears only the bits it returned, so an event
    // between the data snapshot and the clear is kept; a new event wins
    if (apb_done && !pwrite && paddr == APM_OFS_IRQ_STAT) begin
      next_r.irq_stat = (r.irq_stat & ~r.prdata[APM_IRQ_W-1:0]) | ev;
    end else begin
      next_r.irq_stat = r.irq_stat | ev;
    end
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.state    <= APM_OFF;
      r.irq_mask <= APM_IRQ_MASK_RST;
    end else begin
      r <= next_r;
    end
  end

  // ports straight from flops
  assign prdata      = r.prdata;
  assign pready      = r.pready;
  assign pslverr     = r.pslverr;
  assign tx_out      = r.tx_out;
  assign tx_out_oe   = r.tx_out_oe;
  assign rx_out      = r.rx_out;
  assign pump_enable = r.pump_enable;
  assign valid_level = r.valid_level;
  assign pump_ready  = r.pump_ready;
  assign irq         = r.irq;

endmodule
`default_nettype wire
